// [src/vac_regs.svh]
`ifndef VAC_REGS_SVH
`define VAC_REGS_SVH

// ***********************************
// Register indices (byte address = 4 x index)
// ***********************************
`define VAC_IDX_REFDIV 6'h02
`define VAC_IDX_INTG 6'h03
`define VAC_IDX_FRAC 6'h04
`define VAC_IDX_VCOWORD 6'h05
`define VAC_IDX_MODE 6'h06
`define VAC_IDX_LOCKCFG 6'h07
`define VAC_IDX_CALCFG 6'h0A
`define VAC_IDX_SWREAD 6'h10
`define VAC_IDX_STATUS 6'h12

// ***********************************
// Field positions
// ***********************************
`define VAC_FRACMODE_BIT 11
`define VAC_RELOCK_BIT 13
`define VAC_CALDIS_BIT 11
`define VAC_NCODE_LSB 0
`define VAC_MCODE_LSB 13
`define VAC_FRAC_BITS 24
`define VAC_REFDIV_BITS 14
`define VAC_VID_BITS 7
`define VAC_VDATA_BITS 9

// ***********************************
// Timing counts in FSM clocks
// ***********************************
`define VAC_WORD_BITS 16
`define VAC_XFER_CLKS 20
`define VAC_OVH_CLKS 128
`define VAC_OVH_TAIL 2

`endif

// [src/vac_pkg.sv]
package vac_pkg;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } vac_wb_req_t;

   typedef struct packed {
      logic clk;
      logic dat;
      logic en;
   } vac_vs_link_t;

   typedef enum logic [2:0] {
      VAC_IDLE,
      VAC_OVH,
      VAC_SEND,
      VAC_MEAS,
      VAC_DECIDE,
      VAC_LOAD
   } vac_state_t;
endpackage

// [src/vac_top.sv]
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "vac_regs.svh"

module vac_top #(
   parameter int INT_W = 19,
   parameter int SW_W = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire vac_pkg::vac_wb_req_t wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ref_i,
   input wire logic vco_i,
   input wire logic lock_i,
   output vac_pkg::vac_vs_link_t vs_link_o,
   output logic [INT_W-1:0] mod_int_o,
   output logic [`VAC_FRAC_BITS-1:0] mod_frac_o,
   output logic mod_load_o,
   output logic cal_busy_o
);
   import vac_pkg::*;

   localparam int CNT_W = INT_W + 8;
   localparam int WIN_W = `VAC_REFDIV_BITS + 8;

   // Refused at elaboration: readout is 8 bits wide, bit index 3 bits
   if (INT_W < 5 || INT_W > 22 || SW_W < 1 || SW_W > 8) begin : g_bad_param
      $error("vac_top: unsupported INT_W or SW_W");
   end

   // ***********************************
   // Helper functions
   // ***********************************
   function automatic logic [3:0] n_of(input logic [2:0] code);
      n_of = code[2] ? {1'b0, code} + 4'h1 : {1'b0, code};
   endfunction

   function automatic logic [4:0] mmask_of(input logic [1:0] code);
      case (code)
         2'h0: mmask_of = 5'h00;
         2'h1: mmask_of = 5'h03;
         2'h2: mmask_of = 5'h0F;
         default: mmask_of = 5'h1F;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   function automatic logic rise(input logic a, input logic b);
      rise = a & ~b;
   endfunction

   // ***********************************
   // Pin synchronisers
   // ***********************************
   logic [2:0] ref_q, vco_q, lock_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_q <= 3'h0;
         vco_q <= 3'h0;
         lock_q <= 3'h0;
      end else begin
         ref_q <= {ref_q[1:0], ref_i};
         vco_q <= {vco_q[1:0], vco_i};
         lock_q <= {lock_q[1:0], lock_i};
      end
   end
   // Stage 0 only feeds stage 1; edges use stages 1 and 2
   wire ref_rise = rise(ref_q[1], ref_q[2]);
   wire vco_rise = rise(vco_q[1], vco_q[2]);
   wire unlock_ev = rise(lock_q[2], lock_q[1]);

   // ***********************************
   // Registers
   // ***********************************
   logic [`VAC_REFDIV_BITS-1:0] refdiv_q;
   logic [INT_W-1:0] intg_q;
   logic [`VAC_FRAC_BITS-1:0] frac_q;
   logic [`VAC_WORD_BITS-1:0] vword_q;
   logic fracmode_q, relock_en_q, caldis_q;
   logic [2:0] ncode_q;
   logic [1:0] mcode_q;
   logic [7:0] swread_q;
   logic relock_used_q;
   logic start_pend_q, fwd_pend_q;

   wire req = wb_req_i.cyc & wb_req_i.stb;
   wire [5:0] idx = wb_req_i.adr[7:2];
   // Write lands on the edge where the master sees ack
   wire wr_fire = req & wb_req_i.we & wb_ack_o;
   wire [31:0] wd = wb_req_i.dat;
   wire [3:0] ws = wb_req_i.sel;
   wire wr_refdiv = wr_fire && idx == `VAC_IDX_REFDIV;
   wire wr_intg = wr_fire && idx == `VAC_IDX_INTG;
   wire wr_frac = wr_fire && idx == `VAC_IDX_FRAC;
   wire wr_vword = wr_fire && idx == `VAC_IDX_VCOWORD;
   wire wr_mode = wr_fire && idx == `VAC_IDX_MODE;
   wire wr_lock = wr_fire && idx == `VAC_IDX_LOCKCFG;
   wire wr_cal = wr_fire && idx == `VAC_IDX_CALCFG;

   wire [31:0] intg_w = merge(32'(intg_q), wd, ws);
   wire [31:0] frac_w = merge(32'(frac_q), wd, ws);
   wire [31:0] ref_w = merge(32'(refdiv_q), wd, ws);
   wire [31:0] vw_w = merge(32'(vword_q), wd, ws);
   wire [31:0] mode_w = merge(32'h0 | (32'(fracmode_q) << `VAC_FRACMODE_BIT), wd, ws);
   wire [31:0] lock_w = merge(32'h0 | (32'(relock_en_q) << `VAC_RELOCK_BIT), wd, ws);
   wire [31:0] cal_rd = (32'(caldis_q) << `VAC_CALDIS_BIT) | (32'(mcode_q) << `VAC_MCODE_LSB)
                        | (32'(ncode_q) << `VAC_NCODE_LSB);
   wire [31:0] cal_w = merge(cal_rd, wd, ws);

   // Fraction write always requests; integer write only in integer mode
   wire freq_wr = wr_frac | (wr_intg & ~fracmode_q);
   wire cal_trig = freq_wr & ~caldis_q;

   vac_state_t st_q;
   wire idle = st_q == VAC_IDLE;
   wire take_cal = idle & start_pend_q;
   wire take_fwd = idle & ~start_pend_q & fwd_pend_q;
   wire relock_trig = unlock_ev & relock_en_q & ~relock_used_q & ~caldis_q
                      & idle & ~start_pend_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refdiv_q <= `VAC_REFDIV_BITS'(1);
         intg_q <= '0;
         frac_q <= '0;
         vword_q <= 16'h0000;
         fracmode_q <= 1'b0;
         relock_en_q <= 1'b0;
         caldis_q <= 1'b0;
         ncode_q <= 3'h0;
         mcode_q <= 2'h0;
      end else begin
         if (wr_refdiv) refdiv_q <= ref_w[`VAC_REFDIV_BITS-1:0];
         if (wr_intg) intg_q <= intg_w[INT_W-1:0];
         if (wr_frac) frac_q <= frac_w[`VAC_FRAC_BITS-1:0];
         if (wr_vword) vword_q <= vw_w[`VAC_WORD_BITS-1:0];
         if (wr_mode) fracmode_q <= mode_w[`VAC_FRACMODE_BIT];
         if (wr_lock) relock_en_q <= lock_w[`VAC_RELOCK_BIT];
         if (wr_cal) begin
            caldis_q <= cal_w[`VAC_CALDIS_BIT];
            mcode_q <= cal_w[`VAC_MCODE_LSB +: 2];
            ncode_q <= cal_w[`VAC_NCODE_LSB +: 3];
         end
      end
   end

   // New requests win over the take in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_pend_q <= 1'b0;
         fwd_pend_q <= 1'b0;
         relock_used_q <= 1'b0;
      end else begin
         start_pend_q <= (start_pend_q & ~take_cal) | cal_trig | relock_trig;
         fwd_pend_q <= (fwd_pend_q & ~take_fwd) | wr_vword;
         relock_used_q <= (relock_used_q & ~freq_wr) | relock_trig;
      end
   end

   // ***********************************
   // Bus answer
   // ***********************************
   wire [31:0] rd_data =
      idx == `VAC_IDX_REFDIV ? 32'(refdiv_q) :
      idx == `VAC_IDX_INTG ? 32'(intg_q) :
      idx == `VAC_IDX_FRAC ? 32'(frac_q) :
      idx == `VAC_IDX_VCOWORD ? 32'(vword_q) :
      idx == `VAC_IDX_MODE ? 32'(fracmode_q) << `VAC_FRACMODE_BIT :
      idx == `VAC_IDX_LOCKCFG ? 32'(relock_en_q) << `VAC_RELOCK_BIT :
      idx == `VAC_IDX_CALCFG ? cal_rd :
      idx == `VAC_IDX_SWREAD ? 32'(swread_q) :
      idx == `VAC_IDX_STATUS ? {29'h0, relock_used_q, start_pend_q, ~idle} :
      32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= (req & ~wb_ack_o & ~wb_req_i.we) ? rd_data : 32'h0000_0000;
      end
   end

   // ***********************************
   // FSM clock enable from the reference
   // ***********************************
   logic [4:0] div_q;
   wire [4:0] mmask = mmask_of(mcode_q);
   wire fsm_tick = ref_rise && ((div_q & mmask) == mmask);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 5'h00;
      end else if (ref_rise) begin
         div_q <= fsm_tick ? 5'h00 : div_q + 5'h01;
      end
   end

   // ***********************************
   // Calibration engine
   // ***********************************
   logic [SW_W-1:0] trial_q, best_q;
   logic [CNT_W-1:0] best_err_q, vcnt_q;
   logic [WIN_W-1:0] win_q;
   logic [2:0] bit_q;
   logic final_q, manual_q, extra_q;
   logic [8:0] ovh_q;
   logic [4:0] xcnt_q;
   logic [`VAC_WORD_BITS-1:0] shift_q;

   wire [3:0] n_sel = n_of(ncode_q);
   // Window is R x 2^n reference cycles
   wire [WIN_W-1:0] window = WIN_W'({8'h00, refdiv_q} << n_sel);
   wire [INT_W+`VAC_FRAC_BITS+7:0] n_scaled =
      (INT_W+`VAC_FRAC_BITS+8)'({intg_q, frac_q}) << n_sel;
   wire [CNT_W-1:0] expect_cnt = n_scaled[`VAC_FRAC_BITS +: CNT_W];
   wire too_fast = vcnt_q > expect_cnt;
   wire [CNT_W-1:0] err = too_fast ? vcnt_q - expect_cnt : expect_cnt - vcnt_q;
   wire closer = err < best_err_q;
   wire [SW_W-1:0] kept = too_fast ? trial_q : trial_q & ~(SW_W'(1) << bit_q);
   // Trial word keeps the host's ID and address bits untouched
   wire [`VAC_WORD_BITS-1:0] cal_word =
      {`VAC_VDATA_BITS'(trial_q), vword_q[`VAC_VID_BITS-1:0]};
   wire [`VAC_WORD_BITS-1:0] best_word =
      {`VAC_VDATA_BITS'(closer ? trial_q : best_q), vword_q[`VAC_VID_BITS-1:0]};
   wire xfer_end = fsm_tick && xcnt_q == 5'(`VAC_XFER_CLKS - 1);
   wire ovh_end = fsm_tick && ovh_q == 9'h001;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= VAC_IDLE;
         trial_q <= '0;
         best_q <= '0;
         best_err_q <= '1;
         bit_q <= 3'h0;
         final_q <= 1'b0;
         manual_q <= 1'b0;
         extra_q <= 1'b0;
         ovh_q <= 9'h000;
         vcnt_q <= '0;
         win_q <= '0;
      end else begin
         case (st_q)
            VAC_IDLE: begin
               if (take_cal) begin
                  trial_q <= SW_W'(1) << (SW_W - 1);
                  bit_q <= 3'(SW_W - 1);
                  best_err_q <= '1;
                  final_q <= 1'b0;
                  extra_q <= 1'b0;
                  manual_q <= 1'b0;
                  ovh_q <= 9'(`VAC_OVH_CLKS);
                  st_q <= VAC_OVH;
               end else if (take_fwd) begin
                  manual_q <= 1'b1;
                  st_q <= VAC_SEND;
               end
            end
            VAC_OVH: begin
               if (ovh_end) begin
                  st_q <= final_q ? VAC_LOAD : VAC_SEND;
               end else if (fsm_tick) begin
                  ovh_q <= ovh_q - 9'h001;
               end
            end
            VAC_SEND: begin
               if (xfer_end) begin
                  vcnt_q <= '0;
                  win_q <= '0;
                  if (manual_q) begin
                     st_q <= VAC_IDLE;
                  end else if (final_q) begin
                     ovh_q <= 9'(`VAC_OVH_CLKS * `VAC_OVH_TAIL);
                     st_q <= VAC_OVH;
                  end else begin
                     st_q <= VAC_MEAS;
                  end
               end
            end
            VAC_MEAS: begin
               if (win_q == window) begin
                  st_q <= VAC_DECIDE;
               end else begin
                  if (ref_rise) win_q <= win_q + WIN_W'(1);
                  if (vco_rise) vcnt_q <= vcnt_q + CNT_W'(1);
               end
            end
            VAC_DECIDE: begin
               if (closer) begin
                  best_q <= trial_q;
                  best_err_q <= err;
               end
               if (extra_q || (bit_q == 3'h0 && too_fast)) begin
                  final_q <= 1'b1;
                  st_q <= VAC_SEND;
               end else if (bit_q == 3'h0) begin
                  // Cleared last bit: one more pass measures that setting, zero included
                  trial_q <= kept;
                  extra_q <= 1'b1;
                  st_q <= VAC_SEND;
               end else begin
                  trial_q <= kept | (SW_W'(1) << (bit_q - 3'h1));
                  bit_q <= bit_q - 3'h1;
                  st_q <= VAC_SEND;
               end
            end
            VAC_LOAD: begin
               st_q <= VAC_IDLE;
            end
            default: st_q <= VAC_IDLE;
         endcase
      end
   end

   // ***********************************
   // Internal serial link, MSB first
   // ***********************************
   wire send_start = (st_q == VAC_IDLE && take_fwd) || (st_q == VAC_OVH && ovh_end && !final_q)
                     || st_q == VAC_DECIDE;
   wire [`VAC_WORD_BITS-1:0] next_word =
      st_q == VAC_IDLE ? vword_q :
      (st_q == VAC_DECIDE && (extra_q || (bit_q == 3'h0 && too_fast))) ? best_word :
      st_q == VAC_DECIDE ? {`VAC_VDATA_BITS'(bit_q == 3'h0 ? kept :
                            kept | (SW_W'(1) << (bit_q - 3'h1))),
                            vword_q[`VAC_VID_BITS-1:0]} :
      cal_word;
   wire shifting = st_q == VAC_SEND && xcnt_q < 5'(`VAC_WORD_BITS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xcnt_q <= 5'h00;
         shift_q <= 16'h0000;
         vs_link_o <= '0;
      end else begin
         if (send_start) begin
            shift_q <= next_word;
            xcnt_q <= 5'h00;
         end else if (st_q == VAC_SEND && fsm_tick) begin
            xcnt_q <= xcnt_q + 5'h01;
            if (shifting) shift_q <= {shift_q[`VAC_WORD_BITS-2:0], 1'b0};
         end
         vs_link_o.en <= shifting;
         vs_link_o.dat <= shifting & shift_q[`VAC_WORD_BITS-1];
         // Clock pulse one cycle after each FSM tick, in the last cycle of the bit
         vs_link_o.clk <= shifting & fsm_tick;
      end
   end

   // ***********************************
   // Modulator load and readout
   // ***********************************
   wire direct_ld = freq_wr & caldis_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mod_int_o <= '0;
         mod_frac_o <= '0;
         mod_load_o <= 1'b0;
         swread_q <= 8'h00;
         cal_busy_o <= 1'b0;
      end else begin
         mod_load_o <= direct_ld | (st_q == VAC_LOAD);
         cal_busy_o <= ~idle & ~manual_q;
         if (st_q == VAC_LOAD) begin
            mod_int_o <= intg_q;
            mod_frac_o <= frac_q;
            swread_q <= 8'(best_q);
         end else if (direct_ld) begin
            mod_int_o <= wr_intg ? intg_w[INT_W-1:0] : intg_q;
            mod_frac_o <= wr_frac ? frac_w[`VAC_FRAC_BITS-1:0] : frac_q;
         end
      end
   end
endmodule

// [verification/vac_checker.sv]
`timescale 1ns/1ps
`include "vac_regs.svh"

module vac_checker #(
   parameter int INT_W = 19
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire vac_pkg::vac_wb_req_t wb_req_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire vac_pkg::vac_vs_link_t vs_link_o,
   input wire logic [INT_W-1:0] mod_int_o,
   input wire logic [`VAC_FRAC_BITS-1:0] mod_frac_o,
   input wire logic mod_load_o,
   input wire logic cal_busy_o
);
   import vac_pkg::*;
   logic [4:0] n_clk_q;
   logic [15:0] busy_len_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ***********************************
   // Helper counters
   // ***********************************
   always_ff @(posedge clk_i) begin
      if (rst_i || !vs_link_o.en) begin
         n_clk_q <= 5'h00;
      end else if (vs_link_o.clk) begin
         n_clk_q <= n_clk_q + 5'h01;
      end
   end

   // Busy span in system cycles; a tick is at least two of them
   always_ff @(posedge clk_i) begin
      if (rst_i || !cal_busy_o) begin
         busy_len_q <= 16'h0000;
      end else begin
         busy_len_q <= busy_len_q + 16'h0001;
      end
   end

   // ***********************************
   // Assertions
   // ***********************************
   a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack cycle");
   a_clk_in_frame: assert property (vs_link_o.clk |-> vs_link_o.en)
      else $error("link clock outside frame");
   a_frame_bits: assert property ($fell(vs_link_o.en) |-> n_clk_q == 5'h10)
      else $error("frame not sixteen clocks");
   a_fwd_start: assert property (wb_ack_o && wb_req_i.we && wb_req_i.adr == 8'h14
      && !cal_busy_o |-> ##[1:4] vs_link_o.en)
      else $error("indirect word not forwarded");
   a_mod_on_load: assert property ($changed(mod_int_o) || $changed(mod_frac_o)
      |-> mod_load_o)
      else $error("modulator value changed without load");
   a_load_pulse: assert property (mod_load_o |=> !mod_load_o)
      else $error("load strobe too long");
   a_busy_span: assert property ($fell(cal_busy_o) |-> busy_len_q >= 16'h0320)
      else $error("calibration ended too soon");
endmodule

bind vac_top vac_checker #(.INT_W(INT_W)) u_checker (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_req_i(wb_req_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .vs_link_o(vs_link_o),
   .mod_int_o(mod_int_o),
   .mod_frac_o(mod_frac_o),
   .mod_load_o(mod_load_o),
   .cal_busy_o(cal_busy_o)
);

// [verification/vac_vco_model.sv]
`timescale 1ns/1ps

module vac_vco_model (
   input wire logic clk_i,
   input wire vac_pkg::vac_vs_link_t link_i,
   output logic vco_o,
   output logic [8:0] sw_o,
   output logic [15:0] word_o,
   output int n_word_o
);
   import vac_pkg::*;
   logic [15:0] sh = 16'h0000;
   logic en_q = 1'b0;

   initial begin
      vco_o = 1'b0;
      sw_o = 9'h000;
      word_o = 16'h0000;
      n_word_o = 0;
   end

   // ***********************************
   // Serial receiver
   // ***********************************
   always @(posedge clk_i) begin
      en_q <= link_i.en;
      if (link_i.en && link_i.clk) begin
         sh <= {sh[14:0], link_i.dat};
      end
      if (en_q && !link_i.en) begin
         word_o <= sh;
         n_word_o <= n_word_o + 1;
         if (sh[6:0] == 7'h00) begin
            sw_o <= sh[15:7];
         end
      end
   end

   // ***********************************
   // Oscillator: more capacitance, lower frequency
   // ***********************************
   // Period 50 ns plus 10 ns per step keeps it under the sampler's limit
   always #(25.0 + 5.0 * sw_o) vco_o = ~vco_o;
endmodule

// [verification/vco_auto_calibration_fsm_tb.sv]
`timescale 1ns/1ps
`include "vac_regs.svh"

module vco_auto_calibration_fsm_tb;
   import vac_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ref_i = 1'b0;
   logic lock_i = 1'b1;
   vac_wb_req_t req = '0;
   vac_vs_link_t link;
   logic [31:0] wb_dat, q;
   logic wb_ack, vco, load, busy, ok;
   logic [18:0] m_int;
   logic [23:0] m_frac;
   logic [8:0] sw;
   logic [15:0] word;
   int n_word, n0, t0, n_fail = 0, cmp_count = 0;

   always #5 clk_i = ~clk_i;
   initial begin
      #3.3;
      forever #62.5 ref_i = ~ref_i;
   end

   vac_top #(.INT_W(19), .SW_W(5)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
      .ref_i(ref_i), .vco_i(vco), .lock_i(lock_i), .vs_link_o(link), .mod_int_o(m_int),
      .mod_frac_o(m_frac), .mod_load_o(load), .cal_busy_o(busy)
   );

   vac_vco_model u_vco (
      .clk_i(clk_i), .link_i(link), .vco_o(vco), .sw_o(sw), .word_o(word), .n_word_o(n_word)
   );

   // ***********************************
   // Tasks
   // ***********************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      q = wb_dat;
      req <= '0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask

   // Selector 0 watches busy, 1 the link frame
   task automatic wait_for(input int s, input logic v, input int lim);
      int t;
      ok = 1'b0;
      for (t = 0; t < lim && !ok; t++) begin
         @(posedge clk_i);
         ok = ((s == 0 ? busy : link.en) === v);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk_i);
      n_fail++;
      test_done();
   end

   // ***********************************
   // Tests
   // ***********************************
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h08); chk(q, 32'h1);
      rd(8'h28); chk(q, 32'h0);
      rd(8'h3C); chk(q, 32'h0);
      wr(8'h40, 32'hFF);
      rd(8'h40); chk(q, 32'h0);
      wr(8'h08, 32'h20);
      wr(8'h28, 32'h2);
      n0 = n_word;
      // Model settles on switch 11 for N of 25 at R 32
      wr(8'h0C, 32'h19);
      wait_for(0, 1'b1, 20); chk(32'(ok), 32'h1);
      rd(8'h48); chk(32'(q[0]), 32'h1);
      chk(32'(m_int), 32'h0);
      wait_for(0, 1'b0, 40000); chk(32'(ok), 32'h1);
      repeat (4) @(posedge clk_i);
      chk(32'(m_int), 32'h19);
      chk(32'(sw), 32'hB);
      chk(32'(word[6:0]), 32'h0);
      chk(32'(n_word - n0 <= 7), 32'h1);
      rd(8'h40); chk(q, 32'hB);
      wr(8'h0C, 32'h19);
      wait_for(0, 1'b1, 20); chk(32'(ok), 32'h1);
      wait_for(0, 1'b0, 40000);
      repeat (4) @(posedge clk_i);
      chk(32'(m_int), 32'h19);
      chk(32'(sw), 32'hB);
      wr(8'h1C, 32'h2000);
      lock_i <= 1'b0;
      wait_for(0, 1'b1, 40); chk(32'(ok), 32'h1);
      wait_for(0, 1'b0, 40000);
      lock_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      lock_i <= 1'b0;
      // Relock is spent until the next frequency write
      wait_for(0, 1'b1, 200); chk(32'(ok), 32'h0);
      lock_i <= 1'b1;
      wr(8'h28, 32'h2802);
      wr(8'h14, 32'h380);
      wait_for(1, 1'b1, 10); chk(32'(ok), 32'h1);
      while (link.clk !== 1'b1) @(posedge clk_i);
      t0 = 0;
      do begin
         @(posedge clk_i);
         t0++;
      end while (link.clk !== 1'b1);
      chk(32'(t0 >= 45 && t0 <= 55), 32'h1);
      wait_for(1, 1'b0, 2000);
      // Model latches the word one edge after the frame ends
      repeat (2) @(posedge clk_i);
      chk(32'(word), 32'h380);
      chk(32'(sw), 32'h7);
      wr(8'h0C, 32'h1A);
      repeat (2) @(posedge clk_i);
      chk(32'(m_int), 32'h1A);
      chk(32'(busy), 32'h0);
      // Fractional mode: an integer write waits for the fraction write
      wr(8'h18, 32'h800);
      wr(8'h0C, 32'h1B);
      repeat (2) @(posedge clk_i);
      chk(32'(m_int), 32'h1A);
      wr(8'h10, 32'h123456);
      @(posedge clk_i);
      chk(32'(load), 32'h1);
      @(posedge clk_i);
      chk(32'(load), 32'h0);
      chk(32'(m_frac), 32'h123456);
      chk(32'(m_int), 32'h1B);
      test_done();
   end
endmodule
